// >>> rtl/adma_pkg.sv
// constants for the strobe-level memory module controller
// assumes a 10 MHz core clock and a two-rank module on shared data lines
// Overview of operation
// - wait 200 us after power-up
// - then eight row-strobe cycles before use
// - idle over 16 ms needs eight wake-up cycles
// - row then column on ten address lines
// - row strobe first, column after delay
// - write enable high before column for reads
// - write enable high through whole read
// - row strobe high for precharge between cycles
// - write data referenced to column or write edge
// - refresh all 1024 rows within refresh period
// - never both rank row strobes low
package adma_pkg;
    // ------------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_W        = 10;
    localparam int DATA_W        = 40;
    localparam int WORD_ADDR_W   = 21;

    // ------------------------------------------------------------------
    // timing figures in their own units
    // ------------------------------------------------------------------
    localparam int POWERUP_US      = 200;
    localparam int IDLE_LIMIT_MS   = 16;
    localparam int REFRESH_INT_NS  = 15600;
    localparam int ROW_COL_NS      = 20;
    localparam int PRECHARGE_NS    = 50;
    localparam int ROW_PULSE_NS    = 70;
    localparam int ACCESS_NS       = 70;
    localparam int WRITE_PULSE_NS  = 20;
    localparam int CAS_PRE_NS      = 10;
    localparam int INIT_CYCLES     = 8;

    // ------------------------------------------------------------------
    // cycle counts, least times rounded up, at least one
    // ------------------------------------------------------------------
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int POWERUP_CYC    = cyc_up(POWERUP_US * 1000);
    localparam int IDLE_LIMIT_CYC = (IDLE_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int REFRESH_CYC    = (REFRESH_INT_NS) / CLK_PERIOD_NS;
    localparam int ROW_COL_CYC    = cyc_up(ROW_COL_NS);
    localparam int PRECHARGE_CYC  = cyc_up(PRECHARGE_NS);
    localparam int ROW_PULSE_CYC  = cyc_up(ROW_PULSE_NS);
    localparam int ACCESS_CYC     = cyc_up(ACCESS_NS);
    localparam int WRITE_CYC      = cyc_up(WRITE_PULSE_NS);
    localparam int CAS_PRE_CYC    = cyc_up(CAS_PRE_NS);

    localparam int CNT_W = 24;
    localparam logic [3:0] INIT_LAST = 4'h8;

    // ------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ADMA_POWERUP = 8'h01,
        ADMA_IDLE    = 8'h02,
        ADMA_ROW     = 8'h04,
        ADMA_COL     = 8'h08,
        ADMA_HOLD    = 8'h10,
        ADMA_PRECH   = 8'h20,
        ADMA_REF_CAS = 8'h40,
        ADMA_REF_RAS = 8'h80
    } adma_state_t;
endpackage : adma_pkg

// >>> rtl/adma_timer.sv
// down-counter used for every strobe interval
// assumes loads come from the controller on the same clock
`timescale 1ns/1ps
module adma_timer (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      rstn_i,
    // control
    input  wire logic                      load_i,
    input  wire logic [adma_pkg::CNT_W-1:0] value_i,
    // status
    output logic                           done_o
);
    import adma_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } adma_tmr_t;

    adma_tmr_t r;
    adma_tmr_t next_r;

    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.cnt = value_i;
        end else if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // registered count only, no path back from the load
    assign done_o = (r.cnt == '0);
endmodule : adma_timer

// >>> rtl/adma_ctrl.sv
// host controller driving the module strobes, address and data pins
// assumes user requests on the core clock; data lines are two-way pins
`timescale 1ns/1ps
module adma_ctrl #(
    parameter int POWERUP_CYCLES = adma_pkg::POWERUP_CYC,
    parameter int IDLE_CYCLES    = adma_pkg::IDLE_LIMIT_CYC,
    parameter int REFRESH_CYCLES = adma_pkg::REFRESH_CYC
) (
    // clock and reset
    input  wire logic                         core_clk_i,
    input  wire logic                         rstn_i,
    // user request
    input  wire logic                         req_valid_i,
    input  wire logic                         req_write_i,
    input  wire logic [adma_pkg::WORD_ADDR_W-1:0] req_addr_i,
    input  wire logic [adma_pkg::DATA_W-1:0]  req_wdata_i,
    output logic                              req_ready_o,
    output logic                              rsp_valid_o,
    output logic [adma_pkg::DATA_W-1:0]       rsp_rdata_o,
    output logic                              init_done_o,
    // module pins
    output logic [adma_pkg::ADDR_W-1:0]       mux_address_lines_o,
    output logic                              rank0_row_strobe_n_o,
    output logic                              rank1_row_strobe_n_o,
    output logic                              col_strobe_n_o,
    output logic                              write_en_n_o,
    output logic                              out_en_n_o,
    output logic [adma_pkg::DATA_W-1:0]       data_lines_o,
    output logic                              data_lines_oe_n_o,
    input  wire logic [adma_pkg::DATA_W-1:0]  data_lines_i
);
    import adma_pkg::*;

    typedef struct packed {
        adma_state_t              st;
        logic [3:0]               init_cnt;
        logic                     init_done;
        logic [CNT_W-1:0]         idle_cnt;
        logic [CNT_W-1:0]         ref_cnt;
        logic                     ref_due;
        logic                     ref_rank;
        logic                     pwr_armed;
        logic                     write;
        logic                     rank;
        logic [ADDR_W-1:0]        col;
        logic [DATA_W-1:0]        wdata;
        logic [ADDR_W-1:0]        addr;
        logic                     rank0_row_strobe_n;
        logic                     rank1_row_strobe_n;
        logic                     cas_n;
        logic                     we_n;
        logic                     oe_n;
        logic                     dq_oe_n;
        logic                     rsp_valid;
        logic [DATA_W-1:0]        rdata;
        logic [DATA_W-1:0]        dq_s1;
        logic [DATA_W-1:0]        dq_s2;
    } adma_ctl_t;

    // reset: every strobe and enable inactive
    localparam adma_ctl_t RST_VAL = '{st: ADMA_POWERUP, rank0_row_strobe_n: 1'b1, rank1_row_strobe_n: 1'b1,
                                      cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                      dq_oe_n: 1'b1, default: '0};

    adma_ctl_t        r;
    adma_ctl_t        next_r;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic             tmr_done;
    logic             accept;

    adma_timer u_timer (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .load_i     (tmr_load),
        .value_i    (tmr_value),
        .done_o     (tmr_done)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    assign accept = (r.st == ADMA_IDLE) && r.init_done && !r.ref_due && req_valid_i;

    always_comb begin
        next_r    = r;
        tmr_load  = 1'b0;
        tmr_value = '0;
        next_r.rsp_valid = 1'b0;
        next_r.dq_s1 = data_lines_i;
        next_r.dq_s2 = r.dq_s1;
        // periodic refresh request, one row per interval
        if (r.ref_cnt == '0) begin
            next_r.ref_cnt = CNT_W'(REFRESH_CYCLES);
            next_r.ref_due = 1'b1;
        end else begin
            next_r.ref_cnt = r.ref_cnt - 1'b1;
        end
        // long idle forces a new wake-up burst
        if (r.idle_cnt != '0) begin
            next_r.idle_cnt = r.idle_cnt - 1'b1;
        end else if (r.init_done) begin
            next_r.init_done = 1'b0;
            next_r.init_cnt  = '0;
        end
        case (r.st)
            ADMA_POWERUP: begin
                if (!r.pwr_armed) begin
                    next_r.pwr_armed = 1'b1;
                    tmr_load         = 1'b1;
                    tmr_value        = CNT_W'(POWERUP_CYCLES);
                end else if (tmr_done) begin
                    next_r.st = ADMA_IDLE;
                end
            end
            ADMA_IDLE: begin
                if (!r.init_done || r.ref_due) begin
                    next_r.cas_n = 1'b0;
                    next_r.st    = ADMA_REF_CAS;
                    tmr_load     = 1'b1;
                    tmr_value    = CNT_W'(CAS_PRE_CYC);
                end else if (accept) begin
                    next_r.write = req_write_i;
                    next_r.rank  = req_addr_i[WORD_ADDR_W-1];
                    next_r.col   = req_addr_i[ADDR_W-1:0];
                    next_r.wdata = req_wdata_i;
                    next_r.addr  = req_addr_i[2*ADDR_W-1:ADDR_W];
                    next_r.we_n  = ~req_write_i;
                    next_r.dq_oe_n = ~req_write_i;
                    next_r.st    = ADMA_ROW;
                end
            end
            ADMA_ROW: begin
                // one rank only, the other stays high
                next_r.rank0_row_strobe_n = r.rank;
                next_r.rank1_row_strobe_n = ~r.rank;
                next_r.idle_cnt = CNT_W'(IDLE_CYCLES);
                next_r.st     = ADMA_COL;
                tmr_load      = 1'b1;
                tmr_value     = CNT_W'(ROW_COL_CYC);
            end
            ADMA_COL: begin
                // column address one cycle ahead of its strobe
                next_r.addr = r.col;
                if (tmr_done) begin
                    next_r.cas_n = 1'b0;
                    next_r.oe_n  = r.write;
                    next_r.st    = ADMA_HOLD;
                    tmr_load     = 1'b1;
                    tmr_value    = CNT_W'(ACCESS_CYC + 2);
                end
            end
            ADMA_HOLD: begin
                // read data taken after the two pin flops
                if (tmr_done) begin
                    if (!r.write) begin
                        next_r.rdata     = r.dq_s2;
                        next_r.rsp_valid = 1'b1;
                    end
                    next_r.rank0_row_strobe_n  = 1'b1;
                    next_r.rank1_row_strobe_n  = 1'b1;
                    next_r.cas_n   = 1'b1;
                    next_r.oe_n    = 1'b1;
                    next_r.we_n    = 1'b1;
                    next_r.dq_oe_n = 1'b1;
                    next_r.st      = ADMA_PRECH;
                    tmr_load       = 1'b1;
                    tmr_value      = CNT_W'(PRECHARGE_CYC);
                end
            end
            ADMA_PRECH: begin
                if (tmr_done) begin
                    if (r.ref_rank) begin
                        // second rank of the refresh pair
                        next_r.cas_n = 1'b0;
                        next_r.st    = ADMA_REF_CAS;
                        tmr_load     = 1'b1;
                        tmr_value    = CNT_W'(CAS_PRE_CYC);
                    end else begin
                        next_r.st = ADMA_IDLE;
                    end
                end
            end
            ADMA_REF_CAS: begin
                if (tmr_done) begin
                    next_r.rank0_row_strobe_n   = r.ref_rank;
                    next_r.rank1_row_strobe_n   = ~r.ref_rank;
                    next_r.idle_cnt = CNT_W'(IDLE_CYCLES);
                    next_r.st       = ADMA_REF_RAS;
                    tmr_load        = 1'b1;
                    tmr_value       = CNT_W'(ROW_PULSE_CYC);
                end
            end
            ADMA_REF_RAS: begin
                if (tmr_done) begin
                    next_r.rank0_row_strobe_n   = 1'b1;
                    next_r.rank1_row_strobe_n   = 1'b1;
                    next_r.cas_n    = 1'b1;
                    next_r.ref_rank = ~r.ref_rank;
                    if (r.ref_rank) begin
                        // a new request in this cycle wins over the clear
                        if (r.ref_cnt != '0) begin
                            next_r.ref_due = 1'b0;
                        end
                        if (!r.init_done) begin
                            next_r.init_cnt  = r.init_cnt + 4'h1;
                            next_r.init_done = (r.init_cnt + 4'h1) == INIT_LAST;
                        end
                    end
                    next_r.st = ADMA_PRECH;
                    tmr_load  = 1'b1;
                    tmr_value = CNT_W'(PRECHARGE_CYC);
                end
            end
            default: begin
                next_r = RST_VAL;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= RST_VAL;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign req_ready_o          = (r.st == ADMA_IDLE) && r.init_done && !r.ref_due;
    assign rsp_valid_o          = r.rsp_valid;
    assign rsp_rdata_o          = r.rdata;
    assign init_done_o          = r.init_done;
    assign mux_address_lines_o  = r.addr;
    assign rank0_row_strobe_n_o = r.rank0_row_strobe_n;
    assign rank1_row_strobe_n_o = r.rank1_row_strobe_n;
    assign col_strobe_n_o       = r.cas_n;
    assign write_en_n_o         = r.we_n;
    assign out_en_n_o           = r.oe_n;
    assign data_lines_o         = r.wdata;
    assign data_lines_oe_n_o    = r.dq_oe_n;
endmodule : adma_ctrl

// >>> dv/adma_sva.sv
// checker on the controller pins
// assumes binding to adma_ctrl
`timescale 1ns/1ps
module adma_sva #(
    parameter int POWERUP_CYCLES = 20,
    parameter int REFRESH_CYCLES = 60
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic init_done_o,
    input wire logic rank0_row_strobe_n_o,
    input wire logic rank1_row_strobe_n_o,
    input wire logic col_strobe_n_o,
    input wire logic write_en_n_o,
    input wire logic data_lines_oe_n_o
);
    logic [23:0] age;
    logic [23:0] gap;
    logic [3:0]  nrow;
    wire         rows_n = rank0_row_strobe_n_o & rank1_row_strobe_n_o;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age <= '0;
            gap <= '0;
            nrow <= '0;
        end else begin
            age <= (age == 24'hFFFFFF) ? age : age + 24'h1;
            gap <= $fell(rows_n) ? 24'h0 : gap + 24'h1;
            nrow <= ($fell(rows_n) && nrow != 4'hF) ? nrow + 4'h1 : nrow;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_pwr; age < POWERUP_CYCLES |-> rows_n && col_strobe_n_o; endproperty
    a_pwr: assert property (p_pwr) else $error("strobe during power-up pause");
    property p_init; $rose(init_done_o) |-> nrow >= 4'h8; endproperty
    a_init: assert property (p_init) else $error("ready before eight row cycles");
    property p_excl; rank0_row_strobe_n_o || rank1_row_strobe_n_o; endproperty
    a_excl: assert property (p_excl) else $error("both row strobes low");
    property p_order; $fell(col_strobe_n_o) && !rows_n |-> $past(!rows_n); endproperty
    a_order: assert property (p_order) else $error("column with row strobe");
    property p_prech; $rose(rank0_row_strobe_n_o) |=> rank0_row_strobe_n_o; endproperty
    a_prech: assert property (p_prech) else $error("no precharge");
    property p_rdset; $fell(col_strobe_n_o) && write_en_n_o |-> $past(write_en_n_o); endproperty
    a_rdset: assert property (p_rdset) else $error("read setup missed");
    property p_wdata; $fell(col_strobe_n_o) && !write_en_n_o |-> !data_lines_oe_n_o; endproperty
    a_wdata: assert property (p_wdata) else $error("write data not driven");
    property p_refr; init_done_o |-> gap <= REFRESH_CYCLES + 32; endproperty
    a_refr: assert property (p_refr) else $error("refresh late");
endmodule : adma_sva
bind adma_ctrl adma_sva #(.POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES))
    adma_sva_i (.core_clk_i, .rstn_i, .init_done_o, .rank0_row_strobe_n_o,
    .rank1_row_strobe_n_o, .col_strobe_n_o, .write_en_n_o, .data_lines_oe_n_o);

// >>> dv/adma_dram_model.sv
// behavioural two-rank memory module
// assumes strobes from the controller
`timescale 1ns/1ps
module adma_dram_model #(
    parameter int POWERUP_NS = 2000
) (
    input  wire logic        rank0_row_strobe_n_i,
    input  wire logic        rank1_row_strobe_n_i,
    input  wire logic        col_strobe_n_i,
    input  wire logic        write_en_n_i,
    input  wire logic        out_en_n_i,
    input  wire logic [9:0]  mux_address_lines_i,
    input  wire logic [39:0] data_lines_i,
    output logic      [39:0] q_o,
    output logic             q_en_o,
    output int               refresh_o,
    output logic             viol_o
);
    logic [39:0] mem [bit [20:0]];
    logic [10:0] row = '0;
    logic [9:0]  col = '0;
    logic [3:0]  ninit = '0;
    logic        active = 1'b0;
    wire         rows_n = rank0_row_strobe_n_i & rank1_row_strobe_n_i;
    initial refresh_o = 0;
    initial viol_o = 1'b0;
    initial q_o = '0;
    assign q_en_o = active && !rows_n && !col_strobe_n_i && !out_en_n_i && write_en_n_i;
    task automatic store();
        mem[{row, col}] = (ninit > 4'h8) ? data_lines_i : ~data_lines_i;
    endtask : store
    always @(negedge rows_n) begin
        if ($time < POWERUP_NS) viol_o = 1'b1;
        if (ninit != 4'hF) ninit = ninit + 4'h1;
        active = col_strobe_n_i;
        if (!col_strobe_n_i) refresh_o = refresh_o + 1;
        #1 row = {rank1_row_strobe_n_i, mux_address_lines_i};
    end
    always @(negedge col_strobe_n_i) begin
        #1;
        if (active && !rows_n) begin
            col = mux_address_lines_i;
            q_o = mem[{row, col}];
            if (!write_en_n_i) store();
        end
    end
    always @(negedge write_en_n_i) begin
        if (active && !rows_n && !col_strobe_n_i) #1 store();
    end
endmodule : adma_dram_model

// >>> dv/async_dram_module_access_tb_top.sv
// self-checking bench for the controller
// assumes the pin model and the bound checker
`timescale 1ns/1ps
module async_dram_module_access_tb_top;
    import adma_pkg::*;
    localparam int RC = 60;
    localparam logic [20:0] ADRS [6] = '{21'h000000, 21'h0FFFFF, 21'h100000,
                                          21'h1FFFFF, 21'h0003FF, 21'h0FFC00};
    logic core_clk_i, rstn_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o;
    logic init_done_o, rank0_row_strobe_n_o, rank1_row_strobe_n_o, col_strobe_n_o;
    logic write_en_n_o, out_en_n_o, data_lines_oe_n_o, q_en, viol;
    logic [WORD_ADDR_W-1:0] req_addr_i;
    logic [ADDR_W-1:0]      mux_address_lines_o;
    logic [DATA_W-1:0]      req_wdata_i, rsp_rdata_o, data_lines_o, data_lines_i, q;
    logic [DATA_W-1:0]      exp_mem [bit [20:0]];
    int                     nref;
    int                     num_errors = 0;
    int                     cmp_count = 0;
    assign data_lines_i = !data_lines_oe_n_o ? data_lines_o : (q_en ? q : ~data_lines_o);
    adma_ctrl #(.POWERUP_CYCLES(20), .IDLE_CYCLES(200), .REFRESH_CYCLES(RC)) adma_ctrl_i (
        .core_clk_i, .rstn_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
        .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .init_done_o, .mux_address_lines_o,
        .rank0_row_strobe_n_o, .rank1_row_strobe_n_o, .col_strobe_n_o, .write_en_n_o,
        .out_en_n_o, .data_lines_o, .data_lines_oe_n_o, .data_lines_i);
    adma_dram_model #(.POWERUP_NS(2000)) adma_dram_model_i (
        .rank0_row_strobe_n_i(rank0_row_strobe_n_o), .rank1_row_strobe_n_i(rank1_row_strobe_n_o),
        .col_strobe_n_i(col_strobe_n_o), .write_en_n_i(write_en_n_o), .out_en_n_i(out_en_n_o),
        .mux_address_lines_i(mux_address_lines_o), .data_lines_i(data_lines_i), .q_o(q),
        .q_en_o(q_en), .refresh_o(nref), .viol_o(viol));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic xfer(input logic w, input logic [20:0] a, input logic [39:0] d);
        int i;
        @(negedge core_clk_i);
        req_valid_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        i = 0;
        while (req_ready_o !== 1'b1 && i < 500) begin
            @(negedge core_clk_i);
            i++;
        end
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        if (w) exp_mem[a] = d;
        while (!w && rsp_valid_o !== 1'b1 && i < 500) begin
            @(negedge core_clk_i);
            i++;
        end
        if (i >= 500) begin
            num_errors++;
        end else if (!w) begin
            chk(rsp_rdata_o, exp_mem[a]);
        end
    endtask : xfer
    task automatic t_init();
        for (int i = 0; i < 2000 && init_done_o !== 1'b1; i++) @(negedge core_clk_i);
        chk({39'h0, init_done_o}, 40'h1);
    endtask : t_init
    task automatic t_words();
        foreach (ADRS[i]) xfer(1'b1, ADRS[i], 40'h0);
        foreach (ADRS[i]) xfer(1'b1, ADRS[i], {~ADRS[i][18:0], ADRS[i]});
        foreach (ADRS[i]) xfer(1'b0, ADRS[i], 40'h0);
    endtask : t_words
    task automatic t_refresh();
        int n0;
        n0 = nref;
        repeat (10 * RC) @(negedge core_clk_i);
        chk({39'h0, (nref - n0) >= 8}, 40'h1);
        foreach (ADRS[i]) xfer(1'b0, ADRS[i], 40'h0);
    endtask : t_refresh
    initial begin
        rstn_i = 1'b0;
        req_valid_i = 1'b0;
        req_write_i = 1'b0;
        req_addr_i = '0;
        req_wdata_i = '0;
        repeat (2) @(negedge core_clk_i);
        rstn_i = 1'b1;
        t_init();
        t_words();
        t_refresh();
        chk({39'h0, viol}, 40'h0);
        summarize();
    end
endmodule : async_dram_module_access_tb_top
